/* include/spsc_pkg.sv */
/*
 * Constants for the sleep pad state control block: register addresses,
 * reset values, named bit positions and the pad group routing tables.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package spsc_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [31:0] ADDR_SLEEP_PIN_LEVEL_A        = 32'h4480_0054;
	localparam logic [31:0] ADDR_SLEEP_PIN_LEVEL_B        = 32'h4480_0058;
	localparam logic [31:0] ADDR_SLEEP_PIN_DRIVE_ENABLE_A = 32'h4480_005C;

	localparam logic [31:0] RST_SLEEP_PIN_LEVEL           = 32'h8095_A220;
	localparam logic [31:0] RST_SLEEP_PIN_DRIVE_ENABLE_A  = 32'h003F_03E3;
	localparam logic [31:0] READ_UNMAPPED                 = 32'h0000_0000;

	// ************************************************************
	// Named bit positions
	// ************************************************************
	localparam int unsigned BIT_RESET_OUT_LEVEL   = 31;
	localparam int unsigned BIT_USB_DEV_NEG       = 21;
	localparam int unsigned BIT_USB_DEV_POS       = 20;
	localparam int unsigned BIT_USB_HOST_NEG      = 19;
	localparam int unsigned BIT_USB_HOST_POS      = 18;
	localparam int unsigned BIT_EN_USB_DEV        = 8;
	localparam int unsigned BIT_EN_USB_HOST       = 6;
	localparam int unsigned BIT_LEVEL_B_USED_TOP  = 6;
	localparam int unsigned BIT_EN_SDRAM_DATA     = 1;
	localparam int unsigned BIT_EN_STATIC_DATA    = 0;

	// ************************************************************
	// Pad groups
	// ************************************************************
	localparam int unsigned GROUP_COUNT = 35;

	// Level source: 0..31 level A bit, 32..63 level B bit, LVL_NONE fixed low
	localparam int unsigned LVL_B_BASE = 32;
	localparam int unsigned LVL_NONE   = 127;
	// Enable source: 0..31 drive enable A bit, EN_EXTERN from the outer register
	localparam int unsigned EN_EXTERN  = 32;

	localparam int unsigned GROUP_LEVEL_SRC [GROUP_COUNT] = '{
		31, 30, 30, 29, 27, 26, 25, 24, 23, 22,
		21, 20, 19, 18, 17, 16, 15, 14, 13, 12,
		7, 6, 5, 4, 3, 2, 1, 0,
		38, 37, 36, 34, 33, 32,
		127
	};

	localparam int unsigned GROUP_ENABLE_SRC [GROUP_COUNT] = '{
		32, 13, 12, 32, 10, 32, 32, 32, 32, 21,
		8, 8, 6, 6, 32, 32, 5, 32, 4, 32,
		1, 32, 32, 32, 0, 32, 32, 32,
		32, 32, 32, 32, 3, 15,
		14
	};

endpackage

/* hw/spsc_pad_cell.sv */
/*
 * Registered pad drive selector for all pad groups at once.
 * Assumes the sleep flag and the normal-mode drives are on clk_i.
 */
`timescale 1ns/100ps

module spsc_pad_cell #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             sleep_active_i,
	input  wire logic [WIDTH-1:0] normal_level_i,
	input  wire logic [WIDTH-1:0] normal_drive_i,
	input  wire logic [WIDTH-1:0] sleep_level_i,
	input  wire logic [WIDTH-1:0] sleep_hiz_i,
	output logic      [WIDTH-1:0] pad_level_o,
	output logic      [WIDTH-1:0] pad_drive_o
);

	// ************************************************************
	// Drive selection
	// ************************************************************
	// Pads float during reset so nothing fights an external device
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pad_drive_o <= '0;
		end
		else if (sleep_active_i)
		begin
			pad_drive_o <= ~sleep_hiz_i;
		end
		else
		begin
			pad_drive_o <= normal_drive_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pad_level_o <= '0;
		end
		else if (sleep_active_i)
		begin
			// Level is only seen where drive is on
			pad_level_o <= sleep_level_i & ~sleep_hiz_i;
		end
		else
		begin
			pad_level_o <= normal_level_i;
		end
	end

endmodule

/* hw/spsc_top.sv */
/*
 * Sleep pad state control: three Wishbone registers hold pad levels and
 * drive enables that replace the normal pad drives while the chip sleeps.
 * Assumes sleep_mode_i, stop_mode_i and the normal pad drives are
 * synchronous to clk_i; ext_sleep_hiz_i comes from the outer enable register.
 */
`timescale 1ns/100ps

// Operation
// - Sleep level reaches pad only when driving
// - Enable bit zero drives, one floats
// - USB enables also suspend during stop
// - Level A bit 31 resets out, resets one
// - Level A bits 20/21 USB device lines
// - Level A bits 18/19 USB host lines
// - Level A bits 7..4 SDRAM pin groups
// - Level A bits 3..0 static memory, NAND
// - Level A bit 28, 11..8 no pins
// - Level B bits 6..0 only; bit6 write-enable
// - Level B bits 5,4,2,1,0 pin map
// - Both level registers reset 0x8095A220
// - Enable A resets 0x003F03E3, field 0x1f
// - Enable bits 21,15..12,10 pin map
// - Enable bits 5,4,3 SPI, audio, SPI-in
// - Enable bits 1,0 float memory buses
module spsc_top (
	input  wire logic                             clk_i,
	input  wire logic                             rst_i,
	input  wire logic                             cyc_i,
	input  wire logic                             stb_i,
	input  wire logic                             we_i,
	input  wire logic [31:0]                      adr_i,
	input  wire logic [3:0]                       sel_i,
	input  wire logic [31:0]                      dat_i,
	output logic      [31:0]                      dat_o,
	output logic                                  ack_o,
	input  wire logic                             sleep_mode_i,
	input  wire logic                             stop_mode_i,
	input  wire logic [spsc_pkg::GROUP_COUNT-1:0] normal_level_i,
	input  wire logic [spsc_pkg::GROUP_COUNT-1:0] normal_drive_i,
	input  wire logic [spsc_pkg::GROUP_COUNT-1:0] ext_sleep_hiz_i,
	output logic      [spsc_pkg::GROUP_COUNT-1:0] pad_level_o,
	output logic      [spsc_pkg::GROUP_COUNT-1:0] pad_drive_o,
	output logic                                  usb_dev_suspend_o,
	output logic                                  usb_host_suspend_o
);

	logic [31:0] sleep_pin_level_a_r;
	logic [31:0] sleep_pin_level_b_r;
	logic [31:0] sleep_pin_drive_enable_a_r;
	logic [31:0] read_nxt;
	logic        access;
	logic        wr_level_a;
	logic        wr_level_b;
	logic        wr_enable_a;
	logic [63:0] level_all;
	logic [spsc_pkg::GROUP_COUNT-1:0] group_level;
	logic [spsc_pkg::GROUP_COUNT-1:0] group_hiz;

	// Byte-lane merge used by all three registers
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0]  lanes
	);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++)
		begin
			if (lanes[i])
			begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Write strobe for one register address, shared by all three registers
	function automatic logic write_hit(
		input logic        req,
		input logic        wr,
		input logic [31:0] addr,
		input logic [31:0] reg_addr
	);
		return req & wr & (addr == reg_addr);
	endfunction

	// ************************************************************
	// Wishbone slave
	// ************************************************************
	// One wait state: ack rises the cycle after the request and falls after
	assign access      = cyc_i & stb_i & ~ack_o;
	assign wr_level_a  = write_hit(access, we_i, adr_i, spsc_pkg::ADDR_SLEEP_PIN_LEVEL_A);
	assign wr_level_b  = write_hit(access, we_i, adr_i, spsc_pkg::ADDR_SLEEP_PIN_LEVEL_B);
	assign wr_enable_a = write_hit(access, we_i, adr_i, spsc_pkg::ADDR_SLEEP_PIN_DRIVE_ENABLE_A);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
		end
		else
		begin
			ack_o <= access;
		end
	end

	always_comb
	begin
		// Unmapped addresses still ack and read as zero
		case (adr_i)
			spsc_pkg::ADDR_SLEEP_PIN_LEVEL_A:        read_nxt = sleep_pin_level_a_r;
			spsc_pkg::ADDR_SLEEP_PIN_LEVEL_B:        read_nxt = sleep_pin_level_b_r;
			spsc_pkg::ADDR_SLEEP_PIN_DRIVE_ENABLE_A: read_nxt = sleep_pin_drive_enable_a_r;
			default:                                 read_nxt = spsc_pkg::READ_UNMAPPED;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dat_o <= spsc_pkg::READ_UNMAPPED;
		end
		else if (access & ~we_i)
		begin
			dat_o <= read_nxt;
		end
	end

	// ************************************************************
	// Sleep registers
	// ************************************************************
	// Reserved bits are stored as written so reads return the last value
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sleep_pin_level_a_r <= spsc_pkg::RST_SLEEP_PIN_LEVEL;
		end
		else if (wr_level_a)
		begin
			sleep_pin_level_a_r <= lane_merge(sleep_pin_level_a_r, dat_i, sel_i);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sleep_pin_level_b_r <= spsc_pkg::RST_SLEEP_PIN_LEVEL;
		end
		else if (wr_level_b)
		begin
			sleep_pin_level_b_r <= lane_merge(sleep_pin_level_b_r, dat_i, sel_i);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sleep_pin_drive_enable_a_r <= spsc_pkg::RST_SLEEP_PIN_DRIVE_ENABLE_A;
		end
		else if (wr_enable_a)
		begin
			sleep_pin_drive_enable_a_r <= lane_merge(sleep_pin_drive_enable_a_r, dat_i, sel_i);
		end
	end

	// ************************************************************
	// Group routing
	// ************************************************************
	// Level A bit 28, bits 11..8 and level B bits 31..7, 3 feed no group
	assign level_all = {sleep_pin_level_b_r, sleep_pin_level_a_r};

	always_comb
	begin
		group_level = '0;
		group_hiz   = '0;
		for (int g = 0; g < spsc_pkg::GROUP_COUNT; g++)
		begin
			// level bit per group from the table
			if (spsc_pkg::GROUP_LEVEL_SRC[g] != spsc_pkg::LVL_NONE)
			begin
				group_level[g] = level_all[spsc_pkg::GROUP_LEVEL_SRC[g][5:0]];
			end
			// enable bit per group, else the outer register
			if (spsc_pkg::GROUP_ENABLE_SRC[g] == spsc_pkg::EN_EXTERN)
			begin
				group_hiz[g] = ext_sleep_hiz_i[g];
			end
			else
			begin
				group_hiz[g] = sleep_pin_drive_enable_a_r[spsc_pkg::GROUP_ENABLE_SRC[g][4:0]];
			end
		end
	end

	spsc_pad_cell #(
		.WIDTH          (spsc_pkg::GROUP_COUNT)
	) u_pad_cell (
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.sleep_active_i (sleep_mode_i),
		.normal_level_i (normal_level_i),
		.normal_drive_i (normal_drive_i),
		.sleep_level_i  (group_level),
		.sleep_hiz_i    (group_hiz),
		.pad_level_o    (pad_level_o),
		.pad_drive_o    (pad_drive_o)
	);

	// ************************************************************
	// Stop-mode USB suspend
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			usb_dev_suspend_o  <= 1'b0;
			usb_host_suspend_o <= 1'b0;
		end
		else
		begin
			usb_dev_suspend_o  <= stop_mode_i
				& sleep_pin_drive_enable_a_r[spsc_pkg::BIT_EN_USB_DEV];
			usb_host_suspend_o <= stop_mode_i
				& sleep_pin_drive_enable_a_r[spsc_pkg::BIT_EN_USB_HOST];
		end
	end

endmodule

/* tb/spsc_top_asserts.sv */
/* Port checker for spsc_top: bus answer, sleep pad override, suspend.
 * Assumes one clk_i domain and bind onto spsc_top. */
`timescale 1ns/100ps
module spsc_top_asserts (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [31:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        sleep_mode_i,
	input wire logic        stop_mode_i,
	input wire logic [34:0] normal_level_i,
	input wire logic [34:0] normal_drive_i,
	input wire logic [34:0] ext_sleep_hiz_i,
	input wire logic [34:0] pad_level_o,
	input wire logic [34:0] pad_drive_o,
	input wire logic        usb_dev_suspend_o,
	input wire logic        usb_host_suspend_o
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	property p_ack; s_req |=> ack_o; endproperty
	a_ack: assert property (p_ack) else $error("no ack after request");
	property p_ack_one; ack_o |=> !ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_unmap; s_req ##0 (!we_i && adr_i[7:0] == 8'h00) |=> dat_o == 32'h0000_0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_ext; sleep_mode_i |=> pad_drive_o[0] == !$past(ext_sleep_hiz_i[0]); endproperty
	a_ext: assert property (p_ext) else $error("outer enable ignored");
	property p_float; sleep_mode_i |=> (pad_level_o & ~pad_drive_o) == 35'h0_0000_0000; endproperty
	a_float: assert property (p_float) else $error("floated pad shows level");
	property p_xtal; sleep_mode_i |=> !pad_level_o[34]; endproperty
	a_xtal: assert property (p_xtal) else $error("crystal pad level high");
	property p_norm;
		!sleep_mode_i |=> pad_drive_o == $past(normal_drive_i) && pad_level_o == $past(normal_level_i);
	endproperty
	a_norm: assert property (p_norm) else $error("normal drive not passed");
	property p_susp; !stop_mode_i |=> !usb_dev_suspend_o && !usb_host_suspend_o; endproperty
	a_susp: assert property (p_susp) else $error("suspend outside stop");
endmodule
bind spsc_top spsc_top_asserts u_spsc_top_asserts (.*);

/* tb/spsc_pad_model.sv */
/* Pad model: resolves each pad group wire from drive and level.
 * Assumes pad outputs of spsc_top on clk_i. */
`timescale 1ns/100ps
module spsc_pad_model (
	input  wire logic        clk_i,
	input  wire logic [34:0] level_i,
	input  wire logic [34:0] drive_i,
	output logic      [34:0] wire_o
);
	logic [34:0] last_r = 35'h0_0000_0000;
	// Undriven pad toggles so a stale value never passes
	always_ff @(posedge clk_i)
	begin
		last_r <= wire_o;
	end
	assign wire_o = (level_i & drive_i) | (~last_r & ~drive_i);
endmodule

/* tb/spsc_top_tb.sv */
/* Self-checking bench for spsc_top over classic Wishbone.
 * Assumes spsc_pkg routing tables and a 50 MHz clock. */
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; $display("unexpected at %0t: %h exp %h", $time, a, b); end end
module spsc_top_tb;
	localparam logic [31:0] LA = spsc_pkg::ADDR_SLEEP_PIN_LEVEL_A;
	localparam logic [31:0] LB = spsc_pkg::ADDR_SLEEP_PIN_LEVEL_B;
	localparam logic [31:0] EA = spsc_pkg::ADDR_SLEEP_PIN_DRIVE_ENABLE_A;
	logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
	logic        sleep_mode_i = 0, stop_mode_i = 0, usb_dev_suspend_o, usb_host_suspend_o;
	logic [3:0]  sel_i = 4'hF;
	logic [31:0] adr_i = 0, dat_i = 0, dat_o, q;
	logic [34:0] normal_level_i = 35'h5_C3C3_3C3C, normal_drive_i = 35'h2_0F0F_F0F0;
	logic [34:0] ext_sleep_hiz_i = 0, pad_level_o, pad_drive_o, pad_wire;
	logic [31:0] pat [3] = '{32'h0000_0000, 32'hFFFF_FFFF, 32'hA5A5_5A5A};
	int          n_errors = 0, checked = 0, cyc_cnt = 0;
	spsc_top u_spsc_top (.*);
	spsc_pad_model u_spsc_pad_model (.clk_i(clk_i), .level_i(pad_level_o),
		.drive_i(pad_drive_o), .wire_o(pad_wire));
	initial
	begin
		forever #10 clk_i = ~clk_i;
	end
	// ****
	// Tasks
	// ****
	// Waits for ack with no limit of its own; the cycle ceiling ends a hang
	task automatic wb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
		cyc_i <= 1'h1; stb_i <= 1'h1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 0; stb_i <= 0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [31:0] a, e);
		wb(0, a, 0, 4'h0);
		`CHK(q, e)
	endtask
	task automatic pads(input logic [31:0] la, lb, en);
		logic [34:0] el, ed;
		int unsigned ls, es;
		for (int g = 0; g < 35; g++)
		begin
			ls = spsc_pkg::GROUP_LEVEL_SRC[g];
			es = spsc_pkg::GROUP_ENABLE_SRC[g];
			ed[g] = ~((es == spsc_pkg::EN_EXTERN) ? ext_sleep_hiz_i[g] : en[es]);
			el[g] = ed[g] & ((ls == spsc_pkg::LVL_NONE) ? 1'b0 : (ls < 32) ? la[ls] : lb[ls - 32]);
		end
		`CHK(pad_drive_o, ed)
		`CHK(pad_level_o, el)
		`CHK(pad_wire & ed, el)
	endtask
	task automatic end_sim();
		$display("n_errors=%0d checked=%0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		if (++cyc_cnt == 5000)
		begin
			n_errors++;
			end_sim();
		end
	end
	// ****
	// Tests
	// ****
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		rd(LA, spsc_pkg::RST_SLEEP_PIN_LEVEL);
		rd(LB, spsc_pkg::RST_SLEEP_PIN_LEVEL);
		rd(EA, spsc_pkg::RST_SLEEP_PIN_DRIVE_ENABLE_A);
		`CHK(q[20:16], 5'h1f)
		sleep_mode_i <= 1; stop_mode_i <= 1;
		repeat (2) @(posedge clk_i);
		pads(spsc_pkg::RST_SLEEP_PIN_LEVEL, spsc_pkg::RST_SLEEP_PIN_LEVEL, q);
		`CHK({usb_dev_suspend_o, usb_host_suspend_o}, 2'h3)
		foreach (pat[i])
		begin
			wb(1, LA, ~pat[i], 4'hF);
			wb(1, LB, pat[i] ^ 32'h0000_0055, 4'hF);
			wb(1, EA, pat[i], 4'hF);
			ext_sleep_hiz_i <= {pat[i][2:0], ~pat[i]};
			repeat (2) @(posedge clk_i);
			pads(~pat[i], pat[i] ^ 32'h0000_0055, pat[i]);
			`CHK({usb_dev_suspend_o, usb_host_suspend_o}, {pat[i][8], pat[i][6]})
			rd(EA, pat[i]);
		end
		stop_mode_i <= 0;
		wb(1, LB, 32'h1234_5678, 4'h5);
		`CHK({usb_dev_suspend_o, usb_host_suspend_o}, 2'h0)
		rd(LB, 32'hA534_5A78);
		wb(1, 32'h0000_0000, 32'hFFFF_FFFF, 4'hF);
		rd(32'h0000_0000, spsc_pkg::READ_UNMAPPED);
		rd(LA, 32'h5A5A_A5A5);
		sleep_mode_i <= 0;
		repeat (2) @(posedge clk_i);
		`CHK(pad_drive_o, normal_drive_i)
		`CHK(pad_level_o, normal_level_i)
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		rd(LA, spsc_pkg::RST_SLEEP_PIN_LEVEL);
		rd(LB, spsc_pkg::RST_SLEEP_PIN_LEVEL);
		rd(EA, spsc_pkg::RST_SLEEP_PIN_DRIVE_ENABLE_A);
		end_sim();
	end
endmodule
